// *** fpt_ctrl.sv ***
// How it works
// - Time advances in 300 ns microcycles; duration is count times period.
// - FP duration depends on operation, addressing, memory and data values.
// - FP loads add an extra for negative or negative zero operands, none for positive.
// - Add/subtract alignment costs 900 ns plus 1.2 us per exponent step, 1.8 us double.
// - Normalizing after add costs 1.2 us per shift in single precision.
// - Multiply costs 600 ns per set multiplier bit, 1.2 us double.
// - Compare of equal values costs 1.2 us extra.
// - Compare of unequal values with same sign costs 2.1 us extra.
// - Integer to float costs 1.2 us per step, steps 220 minus exponent.
// - Float to integer costs 2.1 us per step, nearer of 210 or 230.
// - Modulo costs 900 ns times exponent modulo 16.
// - Single modulo with zero fraction costs 1.8 us extra.
// - Rounding a single result costs 1.2 us.
// - Undefined variable trap on load costs 2.4 us.
// - Overflow trap costs 8.1 us, underflow trap 9.0 us.
// - Conversion error trap on float to integer costs 24.3 us.
// - DMA grant within one read-modify-write cycle plus refresh.
// - Interrupt latency is request to acknowledge plus ack to fetch.
// - Extended integer and non-arithmetic FP ops defer interrupts.
// - Interrupt in FP arithmetic aborts it; restore takes 6.9 us.
// - Aborted FP instruction is re-executed from scratch afterwards.
`timescale 1ns/1ps
`include "fpt_cfg.svh"

module fpt_ctrl (
  // Clock and reset
  input wire logic I_CLK,
  input wire logic I_RESET,
  // Instruction issue
  input wire logic I_START,
  input wire fpt_pkg::fpt_op_t I_OP,
  input wire logic I_DOUBLE,
  input wire logic [11:0] I_BASE_MCYC,
  input wire logic [7:0] I_MEM_MCYC,
  output logic O_READY,
  // Operand attributes
  input wire logic I_OPND_NEG,
  input wire logic I_OPND_NEGZERO,
  input wire logic I_UNDEFINED_VARIABLE_TRAP_ENABLE,
  input wire logic [7:0] I_EXP_DIFF,
  input wire logic [5:0] I_NORM_SHIFTS,
  input wire logic [6:0] I_MULT_ONES,
  input wire logic I_CMP_EQUAL,
  input wire logic I_CMP_SAME_SIGN,
  input wire logic [7:0] I_EXPN,
  input wire logic I_FRAC_ZERO,
  input wire logic I_ROUND,
  input wire logic I_TRAP_OVF,
  input wire logic I_TRAP_UNF,
  input wire logic I_TRAP_CONV,
  // Bus requests
  input wire logic I_DMA_REQUEST_LINE,
  input wire logic I_READ_MODIFY_WRITE_CYCLE,
  output logic O_DMA_GRANT,
  input wire logic I_INTERRUPT_REQUEST_LINE,
  output logic O_INTERRUPT_ACKNOWLEDGE_LINE,
  input wire logic I_HANDLER_DONE,
  // Status
  output logic O_BUSY,
  output logic O_MCYC_TICK,
  output logic O_DONE,
  output logic O_ABORTED,
  output logic O_RESTARTED,
  output logic [15:0] O_CYCLES
);
  import fpt_pkg::*;

  // ==========================================
  // Microcycle sequencing
  fpt_seq_if seq ();

  fpt_tick #(
    .CLKS(`FPT_CLKS_PER_MCYC)
  ) u_tick (
    .clk(I_CLK),
    .rst(I_RESET),
    .seq(seq.tick_mp)
  );

  fpt_cnt u_cnt (
    .clk(I_CLK),
    .rst(I_RESET),
    .seq(seq.cnt_mp)
  );

  // ==========================================
  // Helpers
  function automatic logic [15:0] mc(input int ns);
    return 16'(`FPT_MC(ns));
  endfunction : mc

  function automatic logic [15:0] times(input logic [7:0] n,
    input int ns);
    return 16'(n) * mc(ns);
  endfunction : times

  function automatic logic [7:0] absdiff(input logic [7:0] a,
    input logic [7:0] b);
    return (a > b) ? (a - b) : (b - a);
  endfunction : absdiff

  function automatic logic interruptible(input fpt_op_t op);
    return op == FPT_OP_ADD || op == FPT_OP_SUB || op == FPT_OP_MUL
      || op == FPT_OP_DIV || op == FPT_OP_MOD;
  endfunction : interruptible

  // ==========================================
  // Data dependent cost in microcycles
  logic [15:0] extra;
  logic [15:0] total;
  logic [7:0] f2i_lo;
  logic [7:0] f2i_hi;
  logic [7:0] i2f_n;

  always_comb
  begin
    extra = 16'h0000;
    f2i_lo = absdiff(I_EXPN, 8'(`FPT_F2I_EXP_LO));
    f2i_hi = absdiff(I_EXPN, 8'(`FPT_F2I_EXP_HI));
    i2f_n = (I_EXPN < 8'(`FPT_I2F_EXP))
      ? 8'(`FPT_I2F_EXP) - I_EXPN : 8'h00;
    unique case (I_OP)
      FPT_OP_LDF:
      begin
        if (I_OPND_NEGZERO && !I_UNDEFINED_VARIABLE_TRAP_ENABLE)
          extra = 16'(`FPT_LD_NEGZ_MC);
        else if (I_OPND_NEGZERO)
          extra = mc(`FPT_UV_TRAP_NS);
        else if (I_OPND_NEG)
          extra = 16'(`FPT_LD_NEG_MC);
      end
      FPT_OP_ADD, FPT_OP_SUB:
      begin
        extra = mc(`FPT_ALIGN_NS) + (I_DOUBLE
          ? times(I_EXP_DIFF, `FPT_SHIFT_D_NS)
          : times(I_EXP_DIFF, `FPT_SHIFT_S_NS));
        extra = extra + (I_DOUBLE
          ? times(8'(I_NORM_SHIFTS), `FPT_SHIFT_D_NS)
          : times(8'(I_NORM_SHIFTS), `FPT_SHIFT_S_NS));
      end
      FPT_OP_MUL:
        extra = I_DOUBLE ? times(8'(I_MULT_ONES), `FPT_MULBIT_D_NS)
          : times(8'(I_MULT_ONES), `FPT_MULBIT_S_NS);
      FPT_OP_MOD:
      begin
        extra = times(8'(I_EXPN % 8'(`FPT_MOD_EXP)),
          `FPT_MOD_STEP_NS);
        if (I_FRAC_ZERO)
          extra = extra + (I_DOUBLE ? mc(`FPT_MOD_FZ_D_NS)
            : mc(`FPT_MOD_FZ_S_NS));
      end
      FPT_OP_CMP:
      begin
        if (I_CMP_EQUAL)
          extra = mc(`FPT_CMP_EQ_NS);
        else if (I_CMP_SAME_SIGN)
          extra = mc(`FPT_CMP_SS_NS);
      end
      FPT_OP_I2F:
        extra = times(i2f_n, `FPT_I2F_STEP_NS);
      FPT_OP_F2I:
      begin
        extra = times((f2i_lo < f2i_hi) ? f2i_lo : f2i_hi,
          `FPT_F2I_STEP_NS);
        if (I_EXPN < 8'(`FPT_F2I_LOWEXP))
          extra = extra + mc(`FPT_F2I_LOWEXP_NS);
        if (I_TRAP_CONV)
          extra = extra + mc(`FPT_CONV_TRAP_NS);
      end
      default:
        extra = 16'h0000;
    endcase
    // Rounding and arithmetic traps apply to the arithmetic group
    if (interruptible(I_OP))
    begin
      if (I_ROUND)
        extra = extra + (I_DOUBLE ? mc(`FPT_ROUND_D_NS)
          : mc(`FPT_ROUND_S_NS));
      if (I_TRAP_OVF)
        extra = extra + mc(`FPT_OVF_TRAP_NS);
      if (I_TRAP_UNF)
        extra = extra + mc(`FPT_UNF_TRAP_NS);
    end
    // Base, memory wait and data terms, never below one microcycle
    total = 16'(I_BASE_MCYC) + 16'(I_MEM_MCYC) + extra;
    if (total == 16'h0000)
      total = 16'h0001;
  end

  // ==========================================
  // Control state
  fpt_state_t state_q;
  fpt_state_t state_d;
  fpt_op_t op_q;
  fpt_op_t op_d;
  logic [15:0] cost_q;
  logic [15:0] cost_d;
  logic done_q;
  logic done_d;
  logic ack_q;
  logic ack_d;
  logic abort_q;
  logic abort_d;
  logic rst_q;
  logic rst_d;
  logic load;
  logic [15:0] load_val;

  always_comb
  begin
    state_d = state_q;
    op_d = op_q;
    cost_d = cost_q;
    done_d = 1'b0;
    ack_d = 1'b0;
    abort_d = 1'b0;
    rst_d = 1'b0;
    load = 1'b0;
    load_val = cost_q;
    unique case (state_q)
      FPT_IDLE:
      begin
        // Boundary: a pending interrupt goes ahead of the next issue
        if (I_INTERRUPT_REQUEST_LINE)
          ack_d = 1'b1;
        else if (I_START)
        begin
          op_d = I_OP;
          cost_d = total;
          load = 1'b1;
          load_val = total;
          state_d = FPT_RUN;
        end
      end
      FPT_RUN:
      begin
        if (seq.expire)
        begin
          done_d = 1'b1;
          state_d = FPT_IDLE;
        end
        // Abort points are microcycle ends inside FP arithmetic only
        else if (seq.tick && interruptible(op_q)
          && I_INTERRUPT_REQUEST_LINE)
        begin
          ack_d = 1'b1;
          load = 1'b1;
          load_val = mc(`FPT_RESTORE_NS);
          state_d = FPT_RESTORE;
        end
      end
      FPT_RESTORE:
      begin
        if (seq.expire)
        begin
          abort_d = 1'b1;
          state_d = FPT_HOLD;
        end
      end
      FPT_HOLD:
      begin
        // Full cost again: nothing of the aborted pass is kept
        if (I_HANDLER_DONE)
        begin
          rst_d = 1'b1;
          load = 1'b1;
          load_val = cost_q;
          state_d = FPT_RUN;
        end
      end
    endcase
  end

  always_ff @(posedge I_CLK or posedge I_RESET)
  begin
    if (I_RESET)
    begin
      state_q <= FPT_IDLE;
      op_q <= FPT_OP_INT;
      cost_q <= 16'h0000;
      done_q <= 1'b0;
      ack_q <= 1'b0;
      abort_q <= 1'b0;
      rst_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      op_q <= op_d;
      cost_q <= cost_d;
      done_q <= done_d;
      ack_q <= ack_d;
      abort_q <= abort_d;
      rst_q <= rst_d;
    end
  end

  assign seq.load = load;
  assign seq.load_val = load_val;
  assign seq.restart = load;

  // ==========================================
  // DMA grant: only a running read-modify-write cycle holds it off
  logic grant_q;
  logic grant_d;

  always_comb
  begin
    grant_d = grant_q;
    if (!I_DMA_REQUEST_LINE)
      grant_d = 1'b0;
    else if (!I_READ_MODIFY_WRITE_CYCLE)
      grant_d = 1'b1;
  end

  always_ff @(posedge I_CLK or posedge I_RESET)
  begin
    if (I_RESET)
      grant_q <= 1'b0;
    else
      grant_q <= grant_d;
  end

  // ==========================================
  // Outputs
  assign O_READY = state_q == FPT_IDLE && !I_INTERRUPT_REQUEST_LINE;
  assign O_BUSY = state_q != FPT_IDLE;
  assign O_MCYC_TICK = seq.tick;
  assign O_DONE = done_q;
  assign O_ABORTED = abort_q;
  assign O_RESTARTED = rst_q;
  assign O_CYCLES = cost_q;
  assign O_DMA_GRANT = grant_q;
  assign O_INTERRUPT_ACKNOWLEDGE_LINE = ack_q;
endmodule : fpt_ctrl

// *** fpt_cfg.svh ***
`ifndef FPT_CFG_SVH
`define FPT_CFG_SVH

// ==========================================
// Clock and microcycle
`define FPT_CLK_NS 20
`define FPT_MCYC_NS 300
`define FPT_CLKS_PER_MCYC (`FPT_MCYC_NS / `FPT_CLK_NS)
// Rounds a time up to whole microcycles
`define FPT_MC(ns) (((ns) + `FPT_MCYC_NS - 1) / `FPT_MCYC_NS)

// ==========================================
// Data dependent penalties, in ns
`define FPT_ALIGN_NS 900
`define FPT_SHIFT_S_NS 1200
`define FPT_SHIFT_D_NS 1800
`define FPT_MULBIT_S_NS 600
`define FPT_MULBIT_D_NS 1200
`define FPT_CMP_EQ_NS 1200
`define FPT_CMP_SS_NS 2100
`define FPT_I2F_STEP_NS 1200
`define FPT_F2I_STEP_NS 2100
`define FPT_F2I_LOWEXP_NS 600
`define FPT_MOD_STEP_NS 900
`define FPT_MOD_FZ_S_NS 1800
`define FPT_MOD_FZ_D_NS 1200
`define FPT_ROUND_S_NS 1200
`define FPT_ROUND_D_NS 1800
`define FPT_UV_TRAP_NS 2400
`define FPT_OVF_TRAP_NS 8100
`define FPT_UNF_TRAP_NS 9000
`define FPT_CONV_TRAP_NS 24300
`define FPT_RESTORE_NS 6900
// Worst case bounds the environment may check against
`define FPT_DMA_LAT_NS 4150
`define FPT_INT_LAT_NS 21520

// ==========================================
// Exponent figures and load extras in microcycles
`define FPT_I2F_EXP 220
`define FPT_F2I_EXP_LO 210
`define FPT_F2I_EXP_HI 230
`define FPT_F2I_LOWEXP 20
`define FPT_MOD_EXP 16
`define FPT_LD_NEG_MC 2
`define FPT_LD_NEGZ_MC 5

`endif

// *** fpt_pkg.sv ***
package fpt_pkg;

  // ==========================================
  // Operation classes
  typedef enum logic [3:0] {
    FPT_OP_INT = 4'h0,
    FPT_OP_EIS = 4'h1,
    FPT_OP_LDF = 4'h2,
    FPT_OP_ADD = 4'h3,
    FPT_OP_SUB = 4'h4,
    FPT_OP_MUL = 4'h5,
    FPT_OP_DIV = 4'h6,
    FPT_OP_MOD = 4'h7,
    FPT_OP_CMP = 4'h8,
    FPT_OP_I2F = 4'h9,
    FPT_OP_F2I = 4'ha,
    FPT_OP_FPO = 4'hb
  } fpt_op_t;

  typedef enum logic [1:0] {
    FPT_IDLE = 2'b00,
    FPT_RUN = 2'b01,
    FPT_RESTORE = 2'b11,
    FPT_HOLD = 2'b10
  } fpt_state_t;

endpackage : fpt_pkg

// *** fpt_seq_if.sv ***
`timescale 1ns/1ps

interface fpt_seq_if;
  logic restart;
  logic tick;
  logic load;
  logic [15:0] load_val;
  logic expire;
  logic running;

  modport tick_mp (input restart, output tick);
  modport cnt_mp (input tick, input load, input load_val,
    output expire, output running);
  modport ctl_mp (input tick, input expire, input running,
    output restart, output load, output load_val);
endinterface : fpt_seq_if

// *** fpt_tick.sv ***
`timescale 1ns/1ps

module fpt_tick #(
  parameter int CLKS = 15
) (
  input wire logic clk,
  input wire logic rst,
  fpt_seq_if.tick_mp seq
);
  logic [7:0] cnt_q;
  logic [7:0] cnt_d;

  // Restart realigns phase so an instruction lasts whole microcycles
  always_comb
  begin
    if (seq.restart || cnt_q == 8'(CLKS - 1))
      cnt_d = 8'h00;
    else
      cnt_d = cnt_q + 8'h01;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      cnt_q <= 8'h00;
    else
      cnt_q <= cnt_d;
  end

  // Not gated by restart: load is built from tick, gating would loop
  assign seq.tick = cnt_q == 8'(CLKS - 1);
endmodule : fpt_tick

// *** fpt_cnt.sv ***
`timescale 1ns/1ps

module fpt_cnt (
  input wire logic clk,
  input wire logic rst,
  fpt_seq_if.cnt_mp seq
);
  logic [15:0] cnt_q;
  logic [15:0] cnt_d;

  always_comb
  begin
    cnt_d = cnt_q;
    if (seq.load)
      cnt_d = seq.load_val;
    else if (seq.tick && cnt_q != 16'h0000)
      cnt_d = cnt_q - 16'h0001;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      cnt_q <= 16'h0000;
    else
      cnt_q <= cnt_d;
  end

  // Load never meets a count of one, so expiry needs no load term
  assign seq.expire = seq.tick && cnt_q == 16'h0001;
  assign seq.running = cnt_q != 16'h0000;
endmodule : fpt_cnt

// *** fpt_ctrl_assertions.sv ***
`timescale 1ns/1ps

module fpt_ctrl_assertions (
  // Clock and reset
  input wire logic I_CLK,
  input wire logic I_RESET,
  // Inputs watched
  input wire logic I_START,
  input wire logic I_INTERRUPT_REQUEST_LINE,
  input wire logic I_DMA_REQUEST_LINE,
  input wire logic I_READ_MODIFY_WRITE_CYCLE,
  input wire logic I_HANDLER_DONE,
  // Outputs watched
  input wire logic O_READY,
  input wire logic O_DMA_GRANT,
  input wire logic O_INTERRUPT_ACKNOWLEDGE_LINE,
  input wire logic O_BUSY,
  input wire logic O_MCYC_TICK,
  input wire logic O_DONE,
  input wire logic O_ABORTED,
  input wire logic O_RESTARTED
);
  default clocking cb @(posedge I_CLK);
  endclocking
  default disable iff (I_RESET);

  // ==========================================
  // Issue and microcycle pacing
  property p_start;
    O_READY && I_START |=> O_BUSY;
  endproperty
  a_start: assert property (p_start) else $error("start not taken");
  property p_done;
    O_DONE |-> !O_BUSY && $past(O_BUSY);
  endproperty
  a_done: assert property (p_done) else $error("done without run");
  property p_tick;
    O_MCYC_TICK && O_BUSY |=> !O_MCYC_TICK [*8];
  endproperty
  a_tick: assert property (p_tick) else $error("tick too soon");

  // ==========================================
  // Interrupt abort and restart
  property p_abort;
    O_ABORTED |-> $past(O_INTERRUPT_ACKNOWLEDGE_LINE, 345);
  endproperty
  a_abort: assert property (p_abort) else $error("restore length");
  property p_restart;
    O_RESTARTED |-> $past(I_HANDLER_DONE) && O_BUSY;
  endproperty
  a_restart: assert property (p_restart) else $error("bad restart");
  property p_ack;
    O_INTERRUPT_ACKNOWLEDGE_LINE |-> $past(I_INTERRUPT_REQUEST_LINE);
  endproperty
  a_ack: assert property (p_ack) else $error("ack without request");

  // ==========================================
  // DMA grant
  property p_grant;
    I_DMA_REQUEST_LINE && !I_READ_MODIFY_WRITE_CYCLE |=> O_DMA_GRANT;
  endproperty
  a_grant: assert property (p_grant) else $error("grant late");
  property p_hold;
    !O_DMA_GRANT && I_READ_MODIFY_WRITE_CYCLE |=> !O_DMA_GRANT;
  endproperty
  a_hold: assert property (p_hold) else $error("grant in rmw");
  property p_drop;
    !I_DMA_REQUEST_LINE |=> !O_DMA_GRANT;
  endproperty
  a_drop: assert property (p_drop) else $error("grant kept");
endmodule : fpt_ctrl_assertions

bind fpt_ctrl fpt_ctrl_assertions chk_u (.I_CLK(I_CLK), .I_RESET(I_RESET),
  .I_START(I_START), .I_INTERRUPT_REQUEST_LINE(I_INTERRUPT_REQUEST_LINE),
  .I_DMA_REQUEST_LINE(I_DMA_REQUEST_LINE), .I_HANDLER_DONE(I_HANDLER_DONE),
  .I_READ_MODIFY_WRITE_CYCLE(I_READ_MODIFY_WRITE_CYCLE), .O_READY(O_READY),
  .O_DMA_GRANT(O_DMA_GRANT), .O_BUSY(O_BUSY), .O_MCYC_TICK(O_MCYC_TICK),
  .O_INTERRUPT_ACKNOWLEDGE_LINE(O_INTERRUPT_ACKNOWLEDGE_LINE),
  .O_DONE(O_DONE), .O_ABORTED(O_ABORTED), .O_RESTARTED(O_RESTARTED));

// *** fpt_periph.sv ***
`timescale 1ns/1ps

module fpt_periph (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Bench commands and device answers
  input wire logic irq_go,
  input wire logic dma_go,
  input wire logic ack,
  input wire logic grant,
  // Request lines
  output logic irq_req,
  output logic dma_req
);
  logic [1:0] hold_q;

  // ==========================================
  // Requests held until answered, then released
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      irq_req <= 1'b0;
      dma_req <= 1'b0;
      hold_q <= 2'h0;
    end
    else
    begin
      if (irq_go)
        irq_req <= 1'b1;
      else if (ack)
        irq_req <= 1'b0;
      // Keeps mastership a few cycles, like a short transfer
      if (dma_go)
        dma_req <= 1'b1;
      else if (grant && hold_q == 2'h2)
        dma_req <= 1'b0;
      hold_q <= grant ? hold_q + 2'h1 : 2'h0;
    end
  end
endmodule : fpt_periph

// *** fp_timing_and_interrupt_abort_tb.sv ***
`timescale 1ns/1ps

module fp_timing_and_interrupt_abort_tb;
  import fpt_pkg::*;
  logic clk, rst, start, rmw, hdone, irq_go, dma_go, irq_req, dma_req;
  logic rdy, grant, ack, busy, tick, done, abrt, rst_d;
  logic uv, fz, rnd;
  logic [5:0] nsh;
  logic [7:0] fl, mem, expn, ediff;
  logic [6:0] ones;
  logic [11:0] base;
  logic [15:0] cyc;
  fpt_op_t op;
  int err_count = 0;
  int n_checks = 0;

  // ==========================================
  // Clock, design and far side
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  fpt_ctrl dut_u (.I_CLK(clk), .I_RESET(rst), .I_START(start), .I_OP(op),
    .I_DOUBLE(fl[7]), .I_BASE_MCYC(base), .I_MEM_MCYC(mem), .O_READY(rdy),
    .I_OPND_NEG(fl[0]), .I_OPND_NEGZERO(fl[1]),
    .I_UNDEFINED_VARIABLE_TRAP_ENABLE(uv), .I_EXP_DIFF(ediff),
    .I_NORM_SHIFTS(nsh), .I_MULT_ONES(ones), .I_CMP_EQUAL(fl[2]),
    .I_CMP_SAME_SIGN(fl[3]), .I_EXPN(expn), .I_FRAC_ZERO(fz),
    .I_ROUND(rnd), .I_TRAP_OVF(fl[4]), .I_TRAP_UNF(fl[5]),
    .I_TRAP_CONV(fl[6]), .I_DMA_REQUEST_LINE(dma_req),
    .I_READ_MODIFY_WRITE_CYCLE(rmw), .O_DMA_GRANT(grant),
    .I_INTERRUPT_REQUEST_LINE(irq_req), .O_INTERRUPT_ACKNOWLEDGE_LINE(ack),
    .I_HANDLER_DONE(hdone), .O_BUSY(busy), .O_MCYC_TICK(tick),
    .O_DONE(done), .O_ABORTED(abrt), .O_RESTARTED(rst_d), .O_CYCLES(cyc));

  fpt_periph per_u (.clk(clk), .rst(rst), .irq_go(irq_go), .dma_go(dma_go),
    .ack(ack), .grant(grant), .irq_req(irq_req), .dma_req(dma_req));

  // ==========================================
  // Shared tasks
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic go(input fpt_op_t o, input logic [7:0] f,
    input logic [6:0] m1, input logic [7:0] ex);
    int k;
    k = 0;
    while (rdy !== 1'b1 && k < 500)
    begin
      @(negedge clk);
      k++;
    end
    op = o;
    fl = f;
    ones = m1;
    expn = ex;
    start = 1'b1;
    @(negedge clk);
    start = 1'b0;
  endtask : go

  // Runs one instruction and times it from the taking edge
  task automatic issue(input fpt_op_t o, input logic [7:0] f,
    input logic [6:0] m1, input logic [7:0] ex, input logic [15:0] n);
    int k;
    logic [15:0] nt;
    go(o, f, m1, ex);
    chk(cyc, n);
    chk({15'h0, busy}, 16'h0001);
    k = 1;
    nt = 16'h0000;
    while (done !== 1'b1 && k < 30000)
    begin
      @(negedge clk);
      k++;
      nt = nt + 16'(tick);
    end
    chk(16'(k), 16'(15 * n + 1));
    chk(nt, n);
  endtask : issue

  // ==========================================
  // Scenarios
  task automatic t_basic;
    mem = 8'h01;
    issue(FPT_OP_INT, 8'h00, 7'h00, 8'h00, 16'h0003);
    mem = 8'h00;
    issue(FPT_OP_LDF, 8'h00, 7'h00, 8'h00, 16'h0002);
    issue(FPT_OP_LDF, 8'h01, 7'h00, 8'h00, 16'h0004);
    issue(FPT_OP_LDF, 8'h02, 7'h00, 8'h00, 16'h0007);
  endtask : t_basic

  task automatic t_data;
    issue(FPT_OP_CMP, 8'h04, 7'h00, 8'h00, 16'h0006);
    issue(FPT_OP_CMP, 8'h08, 7'h00, 8'h00, 16'h0009);
    issue(FPT_OP_CMP, 8'h00, 7'h00, 8'h00, 16'h0002);
    issue(FPT_OP_MUL, 8'h00, 7'h05, 8'h00, 16'h000c);
    issue(FPT_OP_MUL, 8'h80, 7'h05, 8'h00, 16'h0016);
    issue(FPT_OP_I2F, 8'h00, 7'h00, 8'hda, 16'h000a);
    issue(FPT_OP_F2I, 8'h00, 7'h00, 8'hd4, 16'h0010);
  endtask : t_data

  task automatic t_trap;
    issue(FPT_OP_MUL, 8'h10, 7'h00, 8'h00, 16'h001d);
    issue(FPT_OP_MUL, 8'h20, 7'h00, 8'h00, 16'h0020);
    issue(FPT_OP_F2I, 8'h40, 7'h00, 8'hd2, 16'h0053);
  endtask : t_trap

  task automatic t_arith;
    ediff = 8'h03;
    issue(FPT_OP_ADD, 8'h00, 7'h00, 8'h00, 16'h0011);
    ediff = 8'h01;
    issue(FPT_OP_SUB, 8'h80, 7'h00, 8'h00, 16'h000b);
    ediff = 8'h00;
    nsh = 6'h02;
    issue(FPT_OP_ADD, 8'h00, 7'h00, 8'h00, 16'h000d);
    nsh = 6'h00;
    rnd = 1'b1;
    issue(FPT_OP_SUB, 8'h00, 7'h00, 8'h00, 16'h0009);
    issue(FPT_OP_DIV, 8'h00, 7'h00, 8'h00, 16'h0006);
    rnd = 1'b0;
    issue(FPT_OP_MOD, 8'h00, 7'h00, 8'h13, 16'h000b);
    fz = 1'b1;
    issue(FPT_OP_MOD, 8'h00, 7'h00, 8'h10, 16'h0008);
    fz = 1'b0;
    uv = 1'b1;
    issue(FPT_OP_LDF, 8'h02, 7'h00, 8'h00, 16'h000a);
    uv = 1'b0;
    issue(FPT_OP_FPO, 8'h00, 7'h00, 8'h00, 16'h0002);
    // Low exponent implies a long shift run: about 20k clocks
    issue(FPT_OP_F2I, 8'h00, 7'h00, 8'h13, 16'h053d);
  endtask : t_arith

  task automatic t_abort;
    int k;
    base = 12'h00a;
    go(FPT_OP_MUL, 8'h00, 7'h00, 8'h00);
    repeat (20) @(negedge clk);
    irq_go = 1'b1;
    @(negedge clk);
    irq_go = 1'b0;
    k = 0;
    while (ack !== 1'b1 && k < 40)
    begin
      @(negedge clk);
      k++;
    end
    chk({15'h0, ack}, 16'h0001);
    k = 0;
    while (abrt !== 1'b1 && k < 400)
    begin
      @(negedge clk);
      k++;
    end
    chk(16'(k), 16'd345);
    hdone = 1'b1;
    @(negedge clk);
    hdone = 1'b0;
    chk({15'h0, rst_d}, 16'h0001);
    k = 1;
    while (done !== 1'b1 && k < 400)
    begin
      @(negedge clk);
      k++;
    end
    chk(16'(k), 16'd151);
    base = 12'h002;
  endtask : t_abort

  task automatic t_eis;
    int k;
    logic early;
    early = 1'b0;
    go(FPT_OP_EIS, 8'h00, 7'h00, 8'h00);
    irq_go = 1'b1;
    @(negedge clk);
    irq_go = 1'b0;
    while (done !== 1'b1)
    begin
      early = early | ack;
      @(negedge clk);
    end
    chk({15'h0, early}, 16'h0000);
    k = 0;
    while (ack !== 1'b1 && k < 5)
    begin
      @(negedge clk);
      k++;
    end
    chk({15'h0, ack}, 16'h0001);
  endtask : t_eis

  task automatic t_dma;
    rmw = 1'b1;
    dma_go = 1'b1;
    @(negedge clk);
    dma_go = 1'b0;
    repeat (5) @(negedge clk);
    chk({15'h0, grant}, 16'h0000);
    rmw = 1'b0;
    @(negedge clk);
    chk({15'h0, grant}, 16'h0001);
    repeat (6) @(negedge clk);
    chk({15'h0, grant}, 16'h0000);
  endtask : t_dma

  // ==========================================
  // Verdict and main sequence
  task automatic results;
    $display("checks=%0d errors=%0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : results

  initial
  begin
    #1000000;
    err_count++;
    results();
  end

  initial
  begin
    rst = 1'b1;
    {start, rmw, hdone, irq_go, dma_go} = 5'h00;
    {uv, fz, rnd} = 3'h0;
    ediff = 8'h00;
    nsh = 6'h00;
    fl = 8'h00;
    mem = 8'h00;
    expn = 8'h00;
    ones = 7'h00;
    base = 12'h002;
    op = FPT_OP_INT;
    repeat (3) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    t_basic();
    t_data();
    t_trap();
    t_arith();
    t_abort();
    t_eis();
    t_dma();
    results();
  end
endmodule : fp_timing_and_interrupt_abort_tb
